/* verilog/regulator_diag_status_bank.sv */
// Read-clear diagnostic registers for the core, analog and auxiliary rails.
// Assumes SPI pins and comparator levels are asynchronous to ref_clk.
//
// Behaviour
// - Core thermal warning reads 1 above warning temperature; resets 0, clears on read.
// - Core thermal shutdown reads 1 once shutdown happened; resets 0, clears on read.
// - Core feedback overvoltage reads 1 above threshold; resets 0, clears on read.
// - Core feedback undervoltage reads 1 below threshold; resets 1, re-evaluated on read.
// - Analog thermal warning valid only with internal pass transistor; resets 0.
// - Analog thermal shutdown reads 1 after shutdown; resets 0, clears on read.
// - Analog overvoltage reads 1 above threshold; resets 0, clears on read.
// - Analog undervoltage reads 1 below threshold; resets 1, re-evaluated on read.
// - Analog current limit reads 1 while limiting; resets 0, clears on read.
// - Analog limit timeout valid only with external PNP; resets 0, clears on read.
// - Aux thermal shutdown reads 1 after shutdown; resets 0, clears on read.
// - Aux overvoltage reads 1 above threshold; resets 0, clears on read.
// - Aux undervoltage reads 1 below threshold; resets 1, re-evaluated on read.
// - Aux current limit and limit timeout latch; both reset 0, clear on read.
`timescale 1ns/1ns
module regulator_diag_status_bank import diag_bank_pkg::*; (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic spiClk,
    input wire logic spiSelect_n,
    input wire logic spiMosi,
    output logic spiMiso,
    output logic spiMisoOe,
    input wire diag_live_s comparators,
    input wire global_flags_s globalFlags,
    input wire logic analogExternalPnp
);

    spi_state_s state;
    spi_state_s next_state;
    logic [14:0] flagVec;
    logic [14:0] liveVec;
    logic sclkRise;
    logic sclkFall;
    logic frameStart;
    logic [7:0] cmdNow;
    logic [7:0] upperByte;

    // ------------------------------------------------------------
    // Flag cells
    // ------------------------------------------------------------
    always_comb begin
        liveVec = comparators;
        liveVec[ANALOG_WARN_BIT] = comparators.analogThermalWarning & ~state.pnpStable;
        liveVec[ANALOG_TIMEOUT_BIT] = comparators.analogLimitTimeout & state.pnpStable;
    end

    for (genvar i = 0; i < FLAG_COUNT; i++) begin : g_flag
        diag_flag_cell #(
            .RESET_VAL(FLAG_RESET[i])
        ) u_cell (
            .ref_clk(ref_clk),
            .reset_n(reset_n),
            .rawLevel(liveVec[i]),
            .clearFlag(state.clearVec[i]),
            .flag(flagVec[i])
        );
    end

    // ------------------------------------------------------------
    // SPI frame engine
    // ------------------------------------------------------------
    always_comb begin
        sclkRise = !state.sclkStable && (state.sclkSync[1] == state.sclkSync[2]) && state.sclkSync[2];
        sclkFall = state.sclkStable && (state.sclkSync[1] == state.sclkSync[2]) && !state.sclkSync[2];
        frameStart = state.csStable && (state.csSync[1] == state.csSync[2]) && !state.csSync[2];
        cmdNow = {state.cmdByte[6:0], state.mosiStable};
        upperByte = globalFlags;
        upperByte[GLOBAL_RESERVED_BIT] = 1'b0;
    end

    always_comb begin
        next_state = state;
        next_state.sclkSync = {state.sclkSync[SYNC_DEPTH-2:0], spiClk};
        next_state.csSync = {state.csSync[SYNC_DEPTH-2:0], spiSelect_n};
        next_state.mosiSync = {state.mosiSync[SYNC_DEPTH-2:0], spiMosi};
        next_state.pnpSync = {state.pnpSync[SYNC_DEPTH-2:0], analogExternalPnp};
        if (state.sclkSync[1] == state.sclkSync[2]) begin
            next_state.sclkStable = state.sclkSync[2];
        end
        if (state.csSync[1] == state.csSync[2]) begin
            next_state.csStable = state.csSync[2];
        end
        if (state.mosiSync[1] == state.mosiSync[2]) begin
            next_state.mosiStable = state.mosiSync[2];
        end
        if (state.pnpSync[1] == state.pnpSync[2]) begin
            next_state.pnpStable = state.pnpSync[2];
        end
        next_state.clearVec = '0;
        next_state.misoOe = !state.csStable;
        if (frameStart) begin
            next_state.bitCount = '0;
            next_state.frameWord = {upperByte, 8'h00};
            next_state.miso = upperByte[7];
            next_state.misoOe = 1'b1;
        end else if (!state.csStable && sclkRise && state.bitCount < 5'(FRAME_BITS)) begin
            next_state.cmdByte = cmdNow;
            next_state.bitCount = state.bitCount + 5'h01;
            if (state.bitCount + 5'h01 == ADDR_BYTE_DONE) begin
                unique case (cmdNow)
                    CMD_CORE_READ: begin
                        next_state.frameWord[7:0] = {2'b00, flagVec[CORE_LSB +: 4], 2'b00};
                        next_state.clearVec = CORE_MASK;
                    end
                    CMD_ANALOG_READ: begin
                        next_state.frameWord[7:0] = {2'b00, flagVec[ANALOG_LSB +: 6]};
                        next_state.clearVec = ANALOG_MASK;
                    end
                    CMD_AUX_READ: begin
                        next_state.frameWord[7:0] = {3'b000, flagVec[AUX_LSB +: 5]};
                        next_state.clearVec = AUX_MASK;
                    end
                    default: begin
                        next_state.frameWord[7:0] = 8'h00;
                    end
                endcase
            end
        end else if (!state.csStable && sclkFall && state.bitCount < 5'(FRAME_BITS)) begin
            next_state.miso = state.frameWord[4'(FRAME_BITS - 1) - state.bitCount[3:0]];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state <= '{sclkSync: '0, csSync: '1, mosiSync: '0, pnpSync: '0, sclkStable: 1'b0,
                       csStable: 1'b1, mosiStable: 1'b0, pnpStable: 1'b0, cmdByte: '0,
                       bitCount: '0, frameWord: '0, clearVec: '0, miso: 1'b0, misoOe: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    assign spiMiso = state.miso;
    assign spiMisoOe = state.misoOe;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_core_warn_held;
        @(posedge ref_clk) disable iff (!reset_n)
        flagVec[14] && !state.clearVec[14] |=> flagVec[14];
    endproperty
    a_core_warn_held: assert property (p_core_warn_held) else $error("core warning lost unread");

    property p_core_ov_held;
        @(posedge ref_clk) disable iff (!reset_n)
        $rose(flagVec[12]) |-> ##1 (flagVec[12] || $past(state.clearVec[12]));
    endproperty
    a_core_ov_held: assert property (p_core_ov_held) else $error("core overvoltage lost unread");

    property p_core_byte;
        @(posedge ref_clk) disable iff (!reset_n)
        state.clearVec[CORE_LSB] |-> state.frameWord[5:2] == $past(flagVec[CORE_LSB +: 4])
            && state.frameWord[7:6] == 2'b00 && state.frameWord[1:0] == 2'b00;
    endproperty
    a_core_byte: assert property (p_core_byte) else $error("core answer byte wrong");

    property p_analog_group;
        @(posedge ref_clk) disable iff (!reset_n)
        state.clearVec[ANALOG_LSB] |-> state.clearVec == ANALOG_MASK;
    endproperty
    a_analog_group: assert property (p_analog_group) else $error("analog read cleared wrong flags");

    property p_aux_only_on_read;
        @(posedge ref_clk) disable iff (!reset_n)
        state.clearVec[AUX_LSB] |-> $past(state.bitCount) == 5'h07 && state.cmdByte == CMD_AUX_READ;
    endproperty
    a_aux_only_on_read: assert property (p_aux_only_on_read) else $error("aux cleared without read");

    property p_miso_idle;
        @(posedge ref_clk) disable iff (!reset_n)
        state.csStable ##1 state.csStable |-> !spiMisoOe;
    endproperty
    a_miso_idle: assert property (p_miso_idle) else $error("MISO driven while deselected");

    property p_reset_values;
        @(posedge ref_clk) disable iff (!reset_n)
        $rose(reset_n) |-> flagVec == FLAG_RESET;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("flag reset values wrong");

    property p_core_group;
        @(posedge ref_clk) disable iff (!reset_n)
        state.clearVec[CORE_LSB] |-> state.clearVec == CORE_MASK;
    endproperty
    a_core_group: assert property (p_core_group) else $error("core read cleared wrong flags");

    property p_aux_group;
        @(posedge ref_clk) disable iff (!reset_n)
        state.clearVec[AUX_LSB] |-> state.clearVec == AUX_MASK;
    endproperty
    a_aux_group: assert property (p_aux_group) else $error("aux read cleared wrong flags");

    property p_analog_byte;
        @(posedge ref_clk) disable iff (!reset_n)
        state.clearVec[ANALOG_LSB] |-> state.frameWord[7:0] == {2'b00, $past(flagVec[ANALOG_LSB +: 6])};
    endproperty
    a_analog_byte: assert property (p_analog_byte) else $error("analog answer byte wrong");

    property p_aux_byte;
        @(posedge ref_clk) disable iff (!reset_n)
        state.clearVec[AUX_LSB] |-> state.frameWord[7:0] == {3'b000, $past(flagVec[AUX_LSB +: 5])};
    endproperty
    a_aux_byte: assert property (p_aux_byte) else $error("aux answer byte wrong");

    property p_warn_gated;
        @(posedge ref_clk) disable iff (!reset_n)
        state.pnpStable [*8] ##1 state.clearVec[ANALOG_WARN_BIT] |=> !flagVec[ANALOG_WARN_BIT];
    endproperty
    a_warn_gated: assert property (p_warn_gated) else $error("analog warning with external PNP");

    property p_timeout_gated;
        @(posedge ref_clk) disable iff (!reset_n)
        (!state.pnpStable) [*8] ##1 state.clearVec[ANALOG_TIMEOUT_BIT] |=> !flagVec[ANALOG_TIMEOUT_BIT];
    endproperty
    a_timeout_gated: assert property (p_timeout_gated) else $error("timeout flag without PNP");

endmodule

/* verilog/diag_bank_pkg.sv */
// Constants and carrier types for the regulator diagnostic status bank.
// Assumes one 125 MHz clock and a 16-bit SPI frame from the host.
package diag_bank_pkg;

    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam int FRAME_BITS = 16;
    localparam logic [4:0] ADDR_BYTE_DONE = 5'h08;
    localparam logic [7:0] CMD_CORE_READ = 8'h1A;
    localparam logic [7:0] CMD_ANALOG_READ = 8'h1C;
    localparam logic [7:0] CMD_AUX_READ = 8'h1E;
    localparam int GLOBAL_RESERVED_BIT = 4;

    // ------------------------------------------------------------
    // Flag vector: positions, reset values, per-register groups
    // ------------------------------------------------------------
    localparam int FLAG_COUNT = 15;
    localparam int CORE_LSB = 11;
    localparam int ANALOG_LSB = 5;
    localparam int AUX_LSB = 0;
    localparam int ANALOG_WARN_BIT = 10;
    localparam int ANALOG_TIMEOUT_BIT = 5;
    localparam logic [14:0] FLAG_RESET = 15'h0884;
    localparam logic [14:0] CORE_MASK = 15'h7800;
    localparam logic [14:0] ANALOG_MASK = 15'h07E0;
    localparam logic [14:0] AUX_MASK = 15'h001F;
    localparam int SYNC_DEPTH = 3;

    // Live comparator levels, packed in flag-vector order
    typedef struct packed {
        logic coreThermalWarning;
        logic coreThermalShutdown;
        logic coreFeedbackOvervoltage;
        logic coreFeedbackUndervoltage;
        logic analogThermalWarning;
        logic analogThermalShutdown;
        logic analogOvervoltage;
        logic analogUndervoltage;
        logic analogCurrentLimit;
        logic analogLimitTimeout;
        logic auxThermalShutdown;
        logic auxOvervoltage;
        logic auxUndervoltage;
        logic auxCurrentLimit;
        logic auxLimitTimeout;
    } diag_live_s;

    // Summary flags returned in the upper byte of every answer
    typedef struct packed {
        logic spiGlobalFlag;
        logic wakeupGlobalFlag;
        logic canGlobalFlag;
        logic reservedGlobal;
        logic ioGlobalFlag;
        logic preregulatorGlobalFlag;
        logic coreRailGlobalFlag;
        logic miscellaneousGlobalFlag;
    } global_flags_s;

    typedef struct packed {
        logic [SYNC_DEPTH-1:0] sync;
        logic stable;
        logic flag;
    } flag_state_s;

    typedef struct packed {
        logic [SYNC_DEPTH-1:0] sclkSync;
        logic [SYNC_DEPTH-1:0] csSync;
        logic [SYNC_DEPTH-1:0] mosiSync;
        logic [SYNC_DEPTH-1:0] pnpSync;
        logic sclkStable;
        logic csStable;
        logic mosiStable;
        logic pnpStable;
        logic [7:0] cmdByte;
        logic [4:0] bitCount;
        logic [15:0] frameWord;
        logic [14:0] clearVec;
        logic miso;
        logic misoOe;
    } spi_state_s;

endpackage

/* verilog/diag_flag_cell.sv */
// One latched diagnostic flag fed by an asynchronous comparator level.
// Assumes clearFlag is a one-cycle pulse on ref_clk.
`timescale 1ns/1ns
module diag_flag_cell import diag_bank_pkg::*; #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic rawLevel,
    input wire logic clearFlag,
    output logic flag
);

    flag_state_s state;
    flag_state_s next_state;

    // ------------------------------------------------------------
    // Sync, latch, re-evaluate on read
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_state.sync = {state.sync[SYNC_DEPTH-2:0], rawLevel};
        if (state.sync[1] == state.sync[2]) begin
            next_state.stable = state.sync[2];
        end
        if (clearFlag) begin
            next_state.flag = state.stable;
        end else begin
            next_state.flag = state.flag | state.stable;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state <= '{sync: '0, stable: RESET_VAL, flag: RESET_VAL};
        end else begin
            state <= next_state;
        end
    end

    assign flag = state.flag;

    property p_flag_held;
        @(posedge ref_clk) disable iff (!reset_n)
        state.flag && !clearFlag |=> state.flag;
    endproperty
    a_flag_held: assert property (p_flag_held) else $error("flag dropped without a read");

    property p_flag_reeval;
        @(posedge ref_clk) disable iff (!reset_n)
        clearFlag |=> state.flag == $past(state.stable);
    endproperty
    a_flag_reeval: assert property (p_flag_reeval) else $error("flag not re-evaluated on read");

    property p_flag_set;
        @(posedge ref_clk) disable iff (!reset_n)
        state.stable ##1 state.stable |-> state.flag;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("active condition not latched");

endmodule

/* verification/spi_host_model.sv */
// Host-side SPI master model that reads the diagnostic bank.
// Assumes mode 0 framing and a bank that samples its pins on ref_clk.
`timescale 1ns/1ns
module spi_host_model (
    input wire logic ref_clk,
    output logic spiClk,
    output logic spiSelect_n,
    output logic spiMosi,
    input wire logic spiMiso
);
    localparam int HALF = 8;

    initial begin
        spiClk = 1'b0;
        spiSelect_n = 1'b1;
        spiMosi = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic frame(input logic [15:0] cmd, output logic [15:0] ans);
        ans = 16'h0000;
        spiSelect_n <= 1'b0;
        spiMosi <= cmd[15];
        wait_clk(HALF);
        for (int i = 15; i >= 0; i--) begin
            spiClk <= 1'b1;
            ans[i] = spiMiso;
            wait_clk(HALF);
            spiClk <= 1'b0;
            if (i > 0) begin
                spiMosi <= cmd[i-1];
            end
            wait_clk(HALF);
        end
        spiSelect_n <= 1'b1;
        // Data line no longer meaningful once deselected
        spiMosi <= ~cmd[0];
        wait_clk(HALF);
    endtask
endmodule

/* verification/regulator_diag_status_bank_test.sv */
// Self-checking bench for the regulator diagnostic status bank.
// Assumes the host model in spi_host_model.sv drives the SPI pins.
`timescale 1ns/1ns
module regulator_diag_status_bank_test;
    import diag_bank_pkg::*;
    logic ref_clk, reset_n, spiClk, spiSelect_n, spiMosi, spiMiso, spiMisoOe, analogExternalPnp;
    diag_live_s comparators;
    global_flags_s globalFlags;
    int miscompares, samples_checked;
    logic misoPin;

    regulator_diag_status_bank dut (.ref_clk(ref_clk), .reset_n(reset_n), .spiClk(spiClk),
        .spiSelect_n(spiSelect_n), .spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoOe(spiMisoOe),
        .comparators(comparators), .globalFlags(globalFlags), .analogExternalPnp(analogExternalPnp));
    spi_host_model host (.ref_clk(ref_clk), .spiClk(spiClk), .spiSelect_n(spiSelect_n),
        .spiMosi(spiMosi), .spiMiso(misoPin));

    // Undriven MISO shows the inverse of its last bit, so a missing enable is seen
    assign misoPin = spiMisoOe ? spiMiso : ~spiMiso;

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic rd(input logic [7:0] cmd, input logic [7:0] expLow);
        logic [15:0] ans;
        logic [15:0] expWord;
        expWord = {globalFlags & ~(8'h01 << GLOBAL_RESERVED_BIT), expLow};
        host.frame({cmd, 8'h00}, ans);
        samples_checked++;
        if (ans !== expWord) begin
            miscompares++;
            $display("BAD %0t cmd %h got %h want %h", $time, cmd, ans, expWord);
        end
        samples_checked++;
        if (spiMisoOe !== 1'b0) begin
            miscompares++;
            $display("BAD %0t output enable still high after frame", $time);
        end
    endtask

    task automatic pulse(input logic [14:0] lv);
        @(posedge ref_clk);
        comparators <= lv;
        repeat (10) @(posedge ref_clk);
        comparators <= '0;
        repeat (10) @(posedge ref_clk);
    endtask

    task automatic set_pnp(input logic v);
        analogExternalPnp <= v;
        repeat (8) @(posedge ref_clk);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_values;
        rd(CMD_CORE_READ, 8'h04);
        rd(CMD_ANALOG_READ, 8'h04);
        rd(CMD_AUX_READ, 8'h04);
        rd(CMD_CORE_READ, 8'h00);
        rd(CMD_ANALOG_READ, 8'h00);
        rd(CMD_AUX_READ, 8'h00);
    endtask

    task automatic t_each_flag;
        logic [7:0] cmd;
        logic [7:0] expLow;
        int pos;
        for (int p = 0; p < 2; p++) begin
            set_pnp(p[0]);
            for (int i = 0; i < FLAG_COUNT; i++) begin
                cmd = (i >= CORE_LSB) ? CMD_CORE_READ : (i >= ANALOG_LSB) ? CMD_ANALOG_READ : CMD_AUX_READ;
                pos = (i >= CORE_LSB) ? i - CORE_LSB + 2 : (i >= ANALOG_LSB) ? i - ANALOG_LSB : i;
                expLow = 8'h01 << pos;
                if ((i == ANALOG_WARN_BIT && p == 1) || (i == ANALOG_TIMEOUT_BIT && p == 0)) begin
                    expLow = 8'h00;
                end
                pulse(15'h0001 << i);
                rd(cmd, expLow);
                rd(cmd, 8'h00);
            end
        end
    endtask

    task automatic t_unknown_cmd;
        globalFlags <= 8'h5A;
        set_pnp(1'b0);
        pulse(CORE_MASK | ANALOG_MASK);
        rd(8'h20, 8'h00);
        rd(CMD_AUX_READ, 8'h00);
        rd(CMD_CORE_READ, 8'h3C);
        rd(CMD_ANALOG_READ, 8'h3E);
        rd(CMD_CORE_READ, 8'h00);
    endtask

    task automatic t_live_hold;
        comparators <= 15'h0002;
        repeat (10) @(posedge ref_clk);
        rd(CMD_AUX_READ, 8'h02);
        rd(CMD_AUX_READ, 8'h02);
        comparators <= '0;
        repeat (10) @(posedge ref_clk);
        rd(CMD_AUX_READ, 8'h02);
        rd(CMD_AUX_READ, 8'h00);
    endtask

    task automatic t_mid_reset;
        pulse(AUX_MASK);
        reset_n <= 1'b0;
        repeat (12) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (8) @(posedge ref_clk);
        rd(CMD_AUX_READ, 8'h04);
        rd(CMD_CORE_READ, 8'h04);
        rd(CMD_ANALOG_READ, 8'h04);
    endtask

    initial begin
        #600000;
        miscompares++;
        $display("BAD %0t run did not finish", $time);
        close_out();
    end

    initial begin
        reset_n = 1'b0;
        analogExternalPnp = 1'b0;
        comparators = '0;
        globalFlags = 8'hFF;
        miscompares = 0;
        samples_checked = 0;
        repeat (12) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (8) @(posedge ref_clk);
        t_reset_values();
        t_each_flag();
        t_unknown_cmd();
        t_live_hold();
        t_mid_reset();
        close_out();
    end
endmodule
